/* File: sost_pkg.sv */
// Behaviour
// - Substrate-bias pin follows source picked by bits [2:0], reset value 0.
// - Mechanical-shutter pin follows source picked by bits [5:3], reset value 1.
// - Flash-strobe pin follows source picked by bits [8:6], reset value 2.
// - Internal test signal follows source picked by bits [11:9], reset value 3.
// - Trigger bits 0-3 start generators 0-3, bits 4-5 substrate channels a and b.
// - Bit 6 starts exposure, bit 7 readout; both set runs readout after exposure.
package sost_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_TRIGGER = 8'h51;
  localparam logic [7:0] ADDR_ROUTING = 8'h60;
  localparam int TRIGGER_W = 8;
  localparam int ROUTING_W = 12;
  localparam int SEL_W = 3;
  localparam int NUM_OUTS = 4;
  localparam logic [7:0] TRIGGER_RST = 8'h00;

  // Field positions and reset values of the four source selectors.
  localparam int SUBSTRATE_LSB = 0;
  localparam int MECH_LSB = 3;
  localparam int STROBE_LSB = 6;
  localparam int TEST_LSB = 9;
  localparam logic [2:0] SUBSTRATE_RST = 3'h0;
  localparam logic [2:0] MECH_RST = 3'h1;
  localparam logic [2:0] STROBE_RST = 3'h2;
  localparam logic [2:0] TEST_RST = 3'h3;
  localparam logic [11:0] ROUTING_RST = {TEST_RST, STROBE_RST, MECH_RST, SUBSTRATE_RST};

  // Trigger bit positions.
  localparam int TRIG_GEN_LSB = 0;
  localparam int TRIG_SUB_LSB = 4;
  localparam int TRIG_EXPOSURE = 6;
  localparam int TRIG_READOUT = 7;

  // Source codes.
  localparam logic [2:0] SRC_MUX_A = 3'h4;
  localparam logic [2:0] SRC_MUX_B = 3'h5;
  localparam logic [2:0] SRC_INVALID = 3'h6;
  localparam logic [2:0] SRC_GEN12 = 3'h7;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic gen1_gen2_mux;
    logic substrate_mux_b;
    logic substrate_mux_a;
    logic [3:0] exposure_gen;
  } sost_src_type;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_EXPOSE = 3'b010,
    SEQ_READOUT = 3'b100
  } sost_seq_type;

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  function automatic logic [2:0] sost_field(input logic [11:0] route, input int idx);
    sost_field = route[idx*SEL_W +: SEL_W];
  endfunction

  // The invalid code drives low so a bad setting cannot pulse a pin.
  function automatic logic sost_pick(input logic [2:0] code, input sost_src_type src);
    logic res;
    res = 1'b0;
    unique case (code)
      3'h0, 3'h1, 3'h2, 3'h3: res = src.exposure_gen[code[1:0]];
      SRC_MUX_A: res = src.substrate_mux_a;
      SRC_MUX_B: res = src.substrate_mux_b;
      SRC_GEN12: res = src.gen1_gen2_mux;
      default: res = 1'b0;
    endcase
    sost_pick = res;
  endfunction

endpackage

/* File: sost_sequencer.sv */
`timescale 1ns/1ps
module sost_sequencer (
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // Start requests and completion
  input wire logic start_exposure_i,
  input wire logic start_readout_i,
  input wire logic exposure_done_i,
  input wire logic readout_done_i,
  // State
  output logic exposure_active_o,
  output logic readout_active_o
);

  sost_pkg::sost_seq_type state_r;
  logic chain_r;

  // ----------------------------------------------------------------
  // Exposure and readout sequence
  // ----------------------------------------------------------------
  // Requests arriving while busy are dropped; software re-triggers.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r <= sost_pkg::SEQ_IDLE;
      chain_r <= 1'b0;
    end else begin
      unique case (state_r)
        sost_pkg::SEQ_IDLE: begin
          if (start_exposure_i) begin
            state_r <= sost_pkg::SEQ_EXPOSE;
            chain_r <= start_readout_i;
          end else if (start_readout_i) begin
            state_r <= sost_pkg::SEQ_READOUT;
          end
        end
        sost_pkg::SEQ_EXPOSE: begin
          if (exposure_done_i) begin
            state_r <= chain_r ? sost_pkg::SEQ_READOUT : sost_pkg::SEQ_IDLE;
            chain_r <= 1'b0;
          end
        end
        sost_pkg::SEQ_READOUT: begin
          if (readout_done_i) begin
            state_r <= sost_pkg::SEQ_IDLE;
          end
        end
        default: begin
          state_r <= sost_pkg::SEQ_IDLE;
          chain_r <= 1'b0;
        end
      endcase
    end
  end

  assign exposure_active_o = (state_r == sost_pkg::SEQ_EXPOSE);
  assign readout_active_o = (state_r == sost_pkg::SEQ_READOUT);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_both_from_idle;
    !exposure_active_o && !readout_active_o && start_exposure_i && start_readout_i;
  endsequence

  sequence s_exposure_alone;
    !exposure_active_o && !readout_active_o && start_exposure_i && !start_readout_i;
  endsequence

  sequence s_exposure_ends;
    exposure_active_o && exposure_done_i;
  endsequence

  // The chain flag is checked when the exposure starts; at its end it only selects between the readout and idle checks.
  property p_chain_armed;
    @(posedge clock_i) disable iff (!nrst_i)
      s_both_from_idle |=> exposure_active_o && chain_r;
  endproperty
  a_chain_armed: assert property (p_chain_armed) else $error("readout request not kept");

  property p_chain_readout;
    @(posedge clock_i) disable iff (!nrst_i)
      chain_r ##0 s_exposure_ends |=> readout_active_o;
  endproperty
  a_chain_readout: assert property (p_chain_readout) else $error("readout did not follow exposure");

  property p_solo_armed;
    @(posedge clock_i) disable iff (!nrst_i)
      s_exposure_alone |=> exposure_active_o && !chain_r;
  endproperty
  a_solo_armed: assert property (p_solo_armed) else $error("readout queued without request");

  property p_exposure_only_ends_idle;
    @(posedge clock_i) disable iff (!nrst_i)
      !chain_r ##0 s_exposure_ends |=> !readout_active_o && !exposure_active_o;
  endproperty
  a_exposure_only_ends_idle: assert property (p_exposure_only_ends_idle) else $error("stray readout");

  property p_readout_start;
    @(posedge clock_i) disable iff (!nrst_i)
      (!exposure_active_o && !readout_active_o && !start_exposure_i && start_readout_i) |=> readout_active_o;
  endproperty
  a_readout_start: assert property (p_readout_start) else $error("readout did not start");

  property p_exposure_start;
    @(posedge clock_i) disable iff (!nrst_i)
      (!exposure_active_o && !readout_active_o && start_exposure_i) |=> exposure_active_o;
  endproperty
  a_exposure_start: assert property (p_exposure_start) else $error("exposure did not start");

  property p_never_both;
    @(posedge clock_i) disable iff (!nrst_i)
      !(exposure_active_o && readout_active_o);
  endproperty
  a_never_both: assert property (p_never_both) else $error("exposure and readout both active");

endmodule

/* File: sost_top.sv */
`timescale 1ns/1ps
module sost_top (
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // Register port from the serial interface
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [11:0] reg_wdata_i,
  output logic [11:0] reg_rdata_o,
  // Sensor timing and internal sources
  input wire logic vertical_sync_i,
  input wire sost_pkg::sost_src_type src_i,
  input wire logic exposure_done_i,
  input wire logic readout_done_i,
  // Exposure-control pins
  output logic substrate_bias_pin_o,
  output logic mechanical_shutter_pin_o,
  output logic flash_strobe_pin_o,
  output logic internal_test_signal_o,
  // Start strobes and sequence state
  output logic [3:0] gen_start_o,
  output logic [1:0] substrate_start_o,
  output logic exposure_active_o,
  output logic readout_active_o
);

  logic [11:0] route_pend_r;
  logic [11:0] route_act_r;
  logic [7:0] trig_pend_r;
  logic [7:0] trig_fire_r;
  logic [3:0] pins_r;
  logic wr_trig;
  logic wr_route;

  assign wr_trig = reg_wr_i && (reg_addr_i == sost_pkg::ADDR_TRIGGER);
  assign wr_route = reg_wr_i && (reg_addr_i == sost_pkg::ADDR_ROUTING);

  // ----------------------------------------------------------------
  // Pending and active settings
  // ----------------------------------------------------------------
  // A write in the sync cycle lands in pending and waits for the next sync.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      route_pend_r <= sost_pkg::ROUTING_RST;
    end else if (wr_route) begin
      route_pend_r <= reg_wdata_i;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      route_act_r <= sost_pkg::ROUTING_RST;
    end else if (vertical_sync_i) begin
      route_act_r <= route_pend_r;
    end
  end

  // Trigger bits self-clear when fired; a new write in that cycle wins.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      trig_pend_r <= sost_pkg::TRIGGER_RST;
    end else if (wr_trig) begin
      trig_pend_r <= reg_wdata_i[7:0];
    end else if (vertical_sync_i) begin
      trig_pend_r <= sost_pkg::TRIGGER_RST;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      trig_fire_r <= sost_pkg::TRIGGER_RST;
    end else begin
      trig_fire_r <= vertical_sync_i ? trig_pend_r : sost_pkg::TRIGGER_RST;
    end
  end

  assign gen_start_o = trig_fire_r[sost_pkg::TRIG_GEN_LSB +: 4];
  assign substrate_start_o = trig_fire_r[sost_pkg::TRIG_SUB_LSB +: 2];

  // ----------------------------------------------------------------
  // Output routing
  // ----------------------------------------------------------------
  // Registered so the pins never glitch while the selector settles.
  genvar k;
  generate
    for (k = 0; k < sost_pkg::NUM_OUTS; k++) begin : g_route
      always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
          pins_r[k] <= 1'b0;
        end else begin
          pins_r[k] <= sost_pkg::sost_pick(sost_pkg::sost_field(route_act_r, k), src_i);
        end
      end
    end
  endgenerate

  assign substrate_bias_pin_o = pins_r[0];
  assign mechanical_shutter_pin_o = pins_r[1];
  assign flash_strobe_pin_o = pins_r[2];
  assign internal_test_signal_o = pins_r[3];

  // ----------------------------------------------------------------
  // Register read-back
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= 12'h000;
    end else if (reg_addr_i == sost_pkg::ADDR_TRIGGER) begin
      reg_rdata_o <= {4'h0, trig_pend_r};
    end else if (reg_addr_i == sost_pkg::ADDR_ROUTING) begin
      reg_rdata_o <= route_pend_r;
    end else begin
      reg_rdata_o <= 12'h000;
    end
  end

  // ----------------------------------------------------------------
  // Exposure and readout sequencing
  // ----------------------------------------------------------------
  sost_sequencer u_seq (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .start_exposure_i(trig_fire_r[sost_pkg::TRIG_EXPOSURE]),
    .start_readout_i(trig_fire_r[sost_pkg::TRIG_READOUT]),
    .exposure_done_i(exposure_done_i),
    .readout_done_i(readout_done_i),
    .exposure_active_o(exposure_active_o),
    .readout_active_o(readout_active_o)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_substrate_route;
    @(posedge clock_i) disable iff (!nrst_i)
      ##1 substrate_bias_pin_o == sost_pkg::sost_pick($past(route_act_r[2:0]), $past(src_i));
  endproperty
  a_substrate_route: assert property (p_substrate_route) else $error("substrate pin misrouted");

  property p_mech_route;
    @(posedge clock_i) disable iff (!nrst_i)
      ##1 mechanical_shutter_pin_o == sost_pkg::sost_pick($past(route_act_r[5:3]), $past(src_i));
  endproperty
  a_mech_route: assert property (p_mech_route) else $error("shutter pin misrouted");

  property p_strobe_route;
    @(posedge clock_i) disable iff (!nrst_i)
      ##1 flash_strobe_pin_o == sost_pkg::sost_pick($past(route_act_r[8:6]), $past(src_i));
  endproperty
  a_strobe_route: assert property (p_strobe_route) else $error("strobe pin misrouted");

  property p_test_route;
    @(posedge clock_i) disable iff (!nrst_i)
      ##1 internal_test_signal_o == sost_pkg::sost_pick($past(route_act_r[11:9]), $past(src_i));
  endproperty
  a_test_route: assert property (p_test_route) else $error("test signal misrouted");

  property p_route_waits_sync;
    @(posedge clock_i) disable iff (!nrst_i)
      !vertical_sync_i |=> $stable(route_act_r);
  endproperty
  a_route_waits_sync: assert property (p_route_waits_sync) else $error("routing changed off sync");

  sequence s_write_then_sync;
    wr_route ##1 (vertical_sync_i && !wr_route);
  endsequence

  property p_write_then_sync;
    @(posedge clock_i) disable iff (!nrst_i)
      s_write_then_sync |=> route_act_r == $past(reg_wdata_i, 2);
  endproperty
  a_write_then_sync: assert property (p_write_then_sync) else $error("routing not applied at sync");

  property p_sync_applies_route;
    @(posedge clock_i) disable iff (!nrst_i)
      vertical_sync_i |=> route_act_r == $past(route_pend_r);
  endproperty
  a_sync_applies_route: assert property (p_sync_applies_route) else $error("pending routing lost at sync");

  property p_route_write;
    @(posedge clock_i) disable iff (!nrst_i)
      wr_route |=> route_pend_r == $past(reg_wdata_i);
  endproperty
  a_route_write: assert property (p_route_write) else $error("routing write not held pending");

  property p_trig_write;
    @(posedge clock_i) disable iff (!nrst_i)
      wr_trig |=> trig_pend_r == $past(reg_wdata_i[7:0]);
  endproperty
  a_trig_write: assert property (p_trig_write) else $error("trigger write not held pending");

  // A write in the sync cycle must survive the self-clear.
  property p_trig_clears;
    @(posedge clock_i) disable iff (!nrst_i)
      vertical_sync_i && !wr_trig |=> trig_pend_r == sost_pkg::TRIGGER_RST;
  endproperty
  a_trig_clears: assert property (p_trig_clears) else $error("trigger not cleared after firing");

  property p_read_trigger;
    @(posedge clock_i) disable iff (!nrst_i)
      (reg_addr_i == sost_pkg::ADDR_TRIGGER) |=> reg_rdata_o == {4'h0, $past(trig_pend_r)};
  endproperty
  a_read_trigger: assert property (p_read_trigger) else $error("trigger read-back wrong");

  property p_read_routing;
    @(posedge clock_i) disable iff (!nrst_i)
      (reg_addr_i == sost_pkg::ADDR_ROUTING) |=> reg_rdata_o == $past(route_pend_r);
  endproperty
  a_read_routing: assert property (p_read_routing) else $error("routing read-back wrong");

  sequence s_sync_fires_exposure;
    (vertical_sync_i && trig_pend_r[sost_pkg::TRIG_EXPOSURE]) ##1 (!exposure_active_o && !readout_active_o);
  endsequence

  property p_sync_fires_exposure;
    @(posedge clock_i) disable iff (!nrst_i)
      s_sync_fires_exposure |=> exposure_active_o;
  endproperty
  a_sync_fires_exposure: assert property (p_sync_fires_exposure) else $error("exposure not started at sync");

  property p_starts_on_sync;
    @(posedge clock_i) disable iff (!nrst_i)
      vertical_sync_i |=> {substrate_start_o, gen_start_o} == $past(trig_pend_r[5:0]);
  endproperty
  a_starts_on_sync: assert property (p_starts_on_sync) else $error("start strobes wrong at sync");

  property p_no_start_off_sync;
    @(posedge clock_i) disable iff (!nrst_i)
      !vertical_sync_i |=> (gen_start_o == 4'h0) && (substrate_start_o == 2'h0);
  endproperty
  a_no_start_off_sync: assert property (p_no_start_off_sync) else $error("start strobe off sync");

endmodule

/* File: sost_partner.sv */
`timescale 1ns/1ps
module sost_partner (
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // Sequence state from the block and response delay
  input wire logic exposure_active_i,
  input wire logic readout_active_i,
  input wire logic [7:0] delay_i,
  // Completion pulses
  output logic exposure_done_o,
  output logic readout_done_o
);
  logic [1:0] state_r;
  logic [7:0] count_r;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r <= 2'b00;
      count_r <= 8'h00;
    end else begin
      state_r <= {exposure_active_i, readout_active_i};
      if ({exposure_active_i, readout_active_i} != state_r) begin
        count_r <= 8'h00;
      end else if (count_r != 8'hff) begin
        count_r <= count_r + 8'h01;
      end
    end
  end

  // Each phase ends once, delay_i + 1 cycles after it began; a large delay models a slow sensor.
  assign exposure_done_o = exposure_active_i && state_r[1] && (count_r == delay_i);
  assign readout_done_o = readout_active_i && state_r[0] && (count_r == delay_i);
endmodule

/* File: test_shutter_output_select_trigger.sv */
`timescale 1ns/1ps
module test_shutter_output_select_trigger;
  // ----------------------------------------------------------------
  // Stimulus and observation
  // ----------------------------------------------------------------
  localparam logic [2:0] CODES [0:6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic reg_wr = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [11:0] reg_wdata = 12'h000;
  logic vsync = 1'b0;
  sost_pkg::sost_src_type src = '0;
  logic [7:0] done_delay = 8'h01;
  logic [11:0] rdata;
  logic [3:0] pins;
  logic [3:0] gen_start;
  logic [1:0] sub_start;
  logic exp_act;
  logic rd_act;
  logic exp_done;
  logic rd_done;
  logic [5:0] acc;
  logic [11:0] route;
  logic [11:0] prev;
  int hits;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cycles = 0;
  wire [1:0] st = {exp_act, rd_act};

  always #2 clock_i = ~clock_i;

  sost_top uut (.clock_i(clock_i), .nrst_i(nrst_i), .reg_wr_i(reg_wr), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_rdata_o(rdata), .vertical_sync_i(vsync), .src_i(src),
    .exposure_done_i(exp_done), .readout_done_i(rd_done), .substrate_bias_pin_o(pins[0]),
    .mechanical_shutter_pin_o(pins[1]), .flash_strobe_pin_o(pins[2]), .internal_test_signal_o(pins[3]),
    .gen_start_o(gen_start), .substrate_start_o(sub_start), .exposure_active_o(exp_act),
    .readout_active_o(rd_act));

  sost_partner far_side (.clock_i(clock_i), .nrst_i(nrst_i), .exposure_active_i(exp_act),
    .readout_active_i(rd_act), .delay_i(done_delay), .exposure_done_o(exp_done), .readout_done_o(rd_done));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic stop_test;
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [11:0] d);
    @(posedge clock_i);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock_i);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [11:0] exp);
    @(posedge clock_i);
    reg_addr <= a;
    @(posedge clock_i);
    #1;
    check(rdata, exp);
  endtask

  task automatic sync;
    @(posedge clock_i);
    vsync <= 1'b1;
    @(posedge clock_i);
    vsync <= 1'b0;
  endtask

  // Samples from just after the current edge, so a pulse launched by it is not missed.
  task automatic watch(input int n);
    acc = 6'h00;
    hits = 0;
    repeat (n) begin
      #1;
      acc = acc | {sub_start, gen_start};
      if ({sub_start, gen_start} !== 6'h00) hits++;
      @(posedge clock_i);
    end
  endtask

  // Codes 0-5 pick source bits 0-5 directly; code 7 picks bit 6.
  task automatic chk_pins(input logic [11:0] r);
    logic [2:0] f;
    logic [3:0] e;
    for (int j = 0; j < 7; j++) begin
      @(posedge clock_i);
      src <= sost_pkg::sost_src_type'(7'h01 << j);
      @(posedge clock_i);
      #1;
      for (int i = 0; i < 4; i++) begin
        f = r[3*i +: 3];
        e[i] = (f == 3'h7) ? (j == 6) : (f == j);
      end
      check({8'h00, pins}, {8'h00, e});
    end
  endtask

  task automatic wait_state(input logic [1:0] w, input bit leave);
    int k;
    k = 0;
    #1;
    while (((st === w) == leave) && k < 300) begin
      @(posedge clock_i);
      #1;
      k++;
    end
    if (k >= 300) check(12'h0, 12'h1);
  endtask

  task automatic seq(input logic [7:0] t, input logic [7:0] dly);
    @(posedge clock_i);
    done_delay <= dly;
    wr(8'h51, {4'h0, t});
    sync;
    if (t[6]) begin
      wait_state(2'b10, 1'b0);
      wait_state(2'b10, 1'b1);
      check({10'h0, st}, {10'h0, 1'b0, t[7]});
    end else begin
      wait_state(2'b01, 1'b0);
    end
    if (t[7]) begin
      wait_state(2'b01, 1'b1);
      check({10'h0, st}, 12'h000);
    end
  endtask

  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch++;
      stop_test;
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clock_i);
    nrst_i <= 1'b1;
    rd(8'h60, 12'h688);
    rd(8'h51, 12'h000);
    rd(8'h00, 12'h000);
    prev = 12'h688;
    chk_pins(prev);
    for (int k = 0; k < 7; k++) begin
      route = {CODES[(k+3)%7], CODES[(k+2)%7], CODES[(k+1)%7], CODES[k]};
      wr(8'h60, route);
      rd(8'h60, route);
      chk_pins(prev);
      sync;
      chk_pins(route);
      prev = route;
    end
    for (int b = 0; b < 6; b++) begin
      wr(8'h51, 12'hf00 | (12'h001 << b));
      rd(8'h51, 12'h001 << b);
      watch(3);
      check({6'h0, acc}, 12'h000);
      sync;
      watch(4);
      check({6'h0, acc}, 12'h001 << b);
      check(12'(hits), 12'h001);
      rd(8'h51, 12'h000);
      sync;
      watch(4);
      check({6'h0, acc}, 12'h000);
    end
    seq(8'hc0, 8'h01);
    seq(8'hc0, 8'h14);
    seq(8'h40, 8'h05);
    seq(8'h80, 8'h05);
    stop_test;
  end
endmodule
